// ### rtl/hshk_pkg.sv
package hshk_pkg;

   // Register offsets on the plain register port (word index)
   localparam logic [3:0] CFG1_OFS = 4'h0;
   localparam logic [3:0] CFG2_OFS = 4'h1;
   localparam logic [3:0] PORT1_OFS = 4'h2;
   localparam logic [3:0] PORT2_OFS = 4'h3;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [3:0] IRQCLR_OFS = 4'h5;
   localparam logic [3:0] ROUTE_OFS = 4'h6;

   // Group configuration field positions
   localparam int OUT_BIT = 0;
   localparam int ACKNOWLEDGE_POLARITY_INVERT_BIT = 1;
   localparam int EDGE_BIT = 2;
   localparam int PULSE_BIT = 3;
   localparam int DBLBUF_BIT = 4;
   localparam int REQUEST_POLARITY_INVERT_BIT = 5;
   localparam int LOCAL_GROUP_RESET_BIT = 6;
   localparam int LONG_ACK_PULSE_OPTION_BIT = 7;
   localparam int DLY_LSB = 8;
   localparam int IRQEN_BIT = 11;
   localparam int GROUP_DMA_ENABLE_BIT = 12;

   // Route register field positions
   localparam int IRQSEL1_LSB = 0;
   localparam int IRQSEL2_LSB = 4;
   localparam int DMASEL1_LSB = 8;
   localparam int DMASEL2_LSB = 10;
   localparam int TCEN_LSB = 12;
   localparam int C3EN_BIT = 14;

   // Reset values
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [15:0] ROUTE_RST = 16'h0000;

   // Zero-delay acknowledge width, ns, and its cycle count at 100 MHz
   localparam int CLK_NS = 10;
   localparam int MIN_ACK_NS = 100;
   localparam logic [7:0] MIN_ACK_CYC = 8'((MIN_ACK_NS + CLK_NS - 1) / CLK_NS);
   // Settling delay step per code count, ns, and cycles
   localparam int DLY_STEP_NS = 100;
   localparam int DLY_STEP_CYC = (DLY_STEP_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [1:0]
   {
      MODE_LEVEL = 2'b00,
      MODE_LEAD = 2'b01,
      MODE_TRAIL = 2'b10
   } hs_mode_t;

   // Pins of one handshake group
   typedef struct packed
   {
      logic ack;
      logic [15:0] data;
      logic [15:0] data_oe;
   } grp_pins_t;

endpackage

// ### rtl/hshk_io.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1: Two groups, each with its own request input and acknowledge output.
// RULE2: Each group picks direction and handshake mode independently.
// RULE3: Modes: level, leading-edge pulse, trailing-edge pulse.
// RULE4: Power-up or local group reset puts the group state machine in idle.
// RULE5: Input group sets data-ready on request; cleared by reading the port.
// RULE6: Output group sets data-ready once write selected; cleared by port write.
// RULE7: Request and acknowledge active high; per-group invert bits flip sense.
// RULE8: Level mode: delay starts at port access, acknowledge asserts when done.
// RULE9: Level mode: wait request low, on next request drop ack, set data-ready.
// RULE10: Leading mode: ack pulse after delay; next request edge sets data-ready.
// RULE11: Leading mode with long pulse: acknowledge starts with the delay.
// RULE12: Trailing mode: ack asserts at access, clears when the delay ends.
// RULE13: Trailing mode zero delay still gives a 100 ns acknowledge pulse.
// RULE14: Trailing mode: next request trailing edge sets data-ready.
// RULE15: Five interrupt sources, each enabled and cleared separately.
// RULE16: Each group routes to one of eleven shared tri-state request lines.
// RULE17: Each group has a DMA enable, its own channel, 16-bit transfers.
// RULE18: DMA request when output ready for data or input ready to read.
// RULE19: DMA channel selection limited to channels five, six, seven.
// RULE20: Settling delay taken from software written configuration bits.
// RULE21: With DMA enabled, DMA request follows data-ready.
// RULE22: With interrupts enabled, group interrupt follows data-ready; here data-ready sets a sticky source held until cleared.
// RULE23: Double-buffered input latches pin data on request active edge.
// RULE24: Double-buffered output copies write buffer to output on request.
// RULE25: Settling delay is a down-counter loaded when the delay starts.
// RULE26: Requests pass a synchroniser before edge detection.
module hshk_io
#(
   parameter int DLY_W = 3
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Register port
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // Handshake group pins
   input wire logic [1:0] request_in_i,
   input wire logic [15:0] group1_data_i,
   input wire logic [15:0] group2_data_i,
   output hshk_pkg::grp_pins_t group1_pins_o,
   output hshk_pkg::grp_pins_t group2_pins_o,
   // DMA terminal count and counter-three edge from the host side
   input wire logic [1:0] dma_tc_i,
   input wire logic cnt3_edge_i,
   // Host request lines
   output logic [10:0] irq_line_o,
   output logic [10:0] irq_line_oe_o,
   output logic [2:0] dma_req_o
);

   // Delay field must fit below the interrupt enable bit and in the 8-bit counter
   if (DLY_W < 1 || DLY_W > 3)
   begin : g_bad_dly
      $error("DLY_W out of range");
   end

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_READY = 2'b01,
      ST_DELAY = 2'b10,
      ST_WAIT = 2'b11
   } hs_state_t;

   // Mode decode from edge and pulse bits
   function automatic hshk_pkg::hs_mode_t mode_of(input logic [15:0] c);
      if (!c[hshk_pkg::PULSE_BIT])
         mode_of = hshk_pkg::MODE_LEVEL;
      else if (c[hshk_pkg::EDGE_BIT])
         mode_of = hshk_pkg::MODE_TRAIL;
      else
         mode_of = hshk_pkg::MODE_LEAD;
   endfunction

   // Delay load: code times step, never below the minimum pulse
   function automatic logic [7:0] dly_of(input logic [15:0] c);
      logic [7:0] d;
      d = 8'(c[hshk_pkg::DLY_LSB +: DLY_W] * hshk_pkg::DLY_STEP_CYC);
      dly_of = (d < hshk_pkg::MIN_ACK_CYC) ? hshk_pkg::MIN_ACK_CYC : d;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   logic [15:0] cfg_reg [2];
   logic [15:0] route_reg;
   logic [4:0] isrc_reg;
   logic [2:0] sync_reg [2];
   hs_state_t st_reg [2];
   logic [7:0] cnt_reg [2];
   logic [1:0] data_ready_flag_reg;
   logic [1:0] ack_reg;
   logic [15:0] wbuf_reg [2];
   logic [15:0] obuf_reg [2];
   logic [15:0] ibuf_reg [2];
   logic [1:0] req_lvl;
   logic [1:0] req_prev_reg;
   logic [1:0] req_rise;
   logic [1:0] req_fall;
   logic [1:0] grp_rd;
   logic [1:0] grp_wr;
   logic [15:0] pin_in [2];
   logic [10:0] irq_next;
   logic [2:0] dma_next;
   logic [4:0] isrc_ev;
   logic [7:0] ack_run_reg;

   assign pin_in[0] = group1_data_i;
   assign pin_in[1] = group2_data_i;

   // Configuration and route registers
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cfg_reg[0] <= hshk_pkg::CFG_RST;
         cfg_reg[1] <= hshk_pkg::CFG_RST;
         route_reg <= hshk_pkg::ROUTE_RST;
      end
      else if (wr_i)
      begin
         if (addr_i == hshk_pkg::CFG1_OFS)
            cfg_reg[0] <= wdata_i; // RULE2 RULE20
         if (addr_i == hshk_pkg::CFG2_OFS)
            cfg_reg[1] <= wdata_i; // RULE2 RULE20
         if (addr_i == hshk_pkg::ROUTE_OFS)
            route_reg <= wdata_i;
      end
   end

   // Per-group port accesses
   assign grp_rd[0] = rd_i && addr_i == hshk_pkg::PORT1_OFS;
   assign grp_rd[1] = rd_i && addr_i == hshk_pkg::PORT2_OFS;
   assign grp_wr[0] = wr_i && addr_i == hshk_pkg::PORT1_OFS;
   assign grp_wr[1] = wr_i && addr_i == hshk_pkg::PORT2_OFS;

   //////////////////////////////////////////////////////////////////////////
   // Two identical handshake groups
   for (genvar g = 0; g < 2; g++)
   begin : grp
      logic out_dir;
      logic access;
      hshk_pkg::hs_mode_t md;
      assign out_dir = cfg_reg[g][hshk_pkg::OUT_BIT];
      assign md = mode_of(cfg_reg[g]); // RULE3
      // Reading an output port has no handshake meaning
      assign access = out_dir ? grp_wr[g] : grp_rd[g];

      // Three-stage synchroniser; last two stages agree before a change counts
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
         if (!nrst_i)
         begin
            sync_reg[g] <= 3'h0;
            req_prev_reg[g] <= 1'b0;
         end
         else
         begin
            sync_reg[g] <= {sync_reg[g][1:0], request_in_i[g]}; // RULE26
            if (sync_reg[g][1] == sync_reg[g][2])
               req_prev_reg[g] <= req_lvl[g];
         end
      end
      // Polarity applied after the synchroniser
      assign req_lvl[g] = (sync_reg[g][1] == sync_reg[g][2])
         ? (sync_reg[g][2] ^ cfg_reg[g][hshk_pkg::REQUEST_POLARITY_INVERT_BIT]) : req_prev_reg[g]; // RULE7
      assign req_rise[g] = req_lvl[g] && !req_prev_reg[g]; // RULE26
      assign req_fall[g] = !req_lvl[g] && req_prev_reg[g];

      // Handshake state machine, delay counter, data-ready and acknowledge
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
         if (!nrst_i)
         begin
            st_reg[g] <= ST_IDLE; // RULE4
            cnt_reg[g] <= 8'h00;
            data_ready_flag_reg[g] <= 1'b0;
            ack_reg[g] <= 1'b0;
         end
         else if (cfg_reg[g][hshk_pkg::LOCAL_GROUP_RESET_BIT])
         begin
            st_reg[g] <= ST_IDLE; // RULE4
            cnt_reg[g] <= 8'h00;
            data_ready_flag_reg[g] <= 1'b0;
            ack_reg[g] <= 1'b0;
         end
         else
         begin
            case (st_reg[g])
               ST_IDLE:
               begin
                  // Write group is ready at once; read group waits for request
                  if (out_dir)
                  begin
                     data_ready_flag_reg[g] <= 1'b1; // RULE6
                     st_reg[g] <= ST_READY;
                  end
                  else if ((md == hshk_pkg::MODE_TRAIL) ? req_fall[g] : req_rise[g])
                  begin
                     data_ready_flag_reg[g] <= 1'b1; // RULE5
                     st_reg[g] <= ST_READY;
                  end
               end
               ST_READY:
               begin
                  if (access)
                  begin
                     data_ready_flag_reg[g] <= 1'b0; // RULE5 RULE6
                     cnt_reg[g] <= (md == hshk_pkg::MODE_TRAIL) ? dly_of(cfg_reg[g])
                        : 8'(cfg_reg[g][hshk_pkg::DLY_LSB +: DLY_W] * hshk_pkg::DLY_STEP_CYC); // RULE25
                     // Trailing mode, or leading with long pulse, raise ack now
                     ack_reg[g] <= md == hshk_pkg::MODE_TRAIL
                        || (md == hshk_pkg::MODE_LEAD && cfg_reg[g][hshk_pkg::LONG_ACK_PULSE_OPTION_BIT]); // RULE11 RULE12
                     st_reg[g] <= ST_DELAY; // RULE8
                  end
                  else if (!out_dir && md == hshk_pkg::MODE_LEVEL)
                     data_ready_flag_reg[g] <= 1'b1;
               end
               ST_DELAY:
               begin
                  if (cnt_reg[g] > 8'h01)
                     cnt_reg[g] <= cnt_reg[g] - 8'h01; // RULE25
                  else
                  begin
                     cnt_reg[g] <= 8'h00;
                     // Trailing ends the pulse; level and leading raise it
                     ack_reg[g] <= md != hshk_pkg::MODE_TRAIL; // RULE8 RULE10 RULE12 RULE13
                     st_reg[g] <= ST_WAIT;
                  end
               end
               ST_WAIT:
               begin
                  // Leading-mode ack drops one step after the delay has passed
                  if (md == hshk_pkg::MODE_LEAD)
                     ack_reg[g] <= 1'b0; // RULE10
                  if (md == hshk_pkg::MODE_LEVEL)
                  begin
                     // First rise after request has gone low starts the next cycle
                     if (!req_lvl[g])
                        cnt_reg[g] <= 8'h01;
                     if (req_rise[g] && cnt_reg[g] == 8'h01)
                     begin
                        ack_reg[g] <= 1'b0; // RULE9
                        data_ready_flag_reg[g] <= 1'b1; // RULE9
                        st_reg[g] <= ST_READY;
                     end
                  end
                  else if ((md == hshk_pkg::MODE_TRAIL) ? req_fall[g] : req_rise[g])
                  begin
                     data_ready_flag_reg[g] <= 1'b1; // RULE10 RULE14
                     st_reg[g] <= ST_READY;
                  end
               end
               default:
                  st_reg[g] <= ST_IDLE;
            endcase
         end
      end

      // Port buffers: single-buffered follows access, double-buffered follows request
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
         if (!nrst_i)
         begin
            wbuf_reg[g] <= 16'h0000;
            obuf_reg[g] <= 16'h0000;
            ibuf_reg[g] <= 16'h0000;
         end
         else
         begin
            if (grp_wr[g])
               wbuf_reg[g] <= wdata_i;
            if (!cfg_reg[g][hshk_pkg::DBLBUF_BIT] && grp_wr[g])
               obuf_reg[g] <= wdata_i;
            else if (cfg_reg[g][hshk_pkg::DBLBUF_BIT]
                     && ((md == hshk_pkg::MODE_TRAIL) ? req_fall[g] : req_rise[g]))
               obuf_reg[g] <= wbuf_reg[g]; // RULE24
            if (cfg_reg[g][hshk_pkg::DBLBUF_BIT]
                && ((md == hshk_pkg::MODE_TRAIL) ? req_fall[g] : req_rise[g]))
               ibuf_reg[g] <= pin_in[g]; // RULE23
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Output pins, registered; data drivers enabled only for output groups
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         group1_pins_o <= '0;
         group2_pins_o <= '0;
      end
      else
      begin
         group1_pins_o.ack <= ack_reg[0] ^ cfg_reg[0][hshk_pkg::ACKNOWLEDGE_POLARITY_INVERT_BIT]; // RULE1 RULE7
         group2_pins_o.ack <= ack_reg[1] ^ cfg_reg[1][hshk_pkg::ACKNOWLEDGE_POLARITY_INVERT_BIT]; // RULE1 RULE7
         group1_pins_o.data <= obuf_reg[0]; // RULE24
         group2_pins_o.data <= obuf_reg[1];
         group1_pins_o.data_oe <= {16{cfg_reg[0][hshk_pkg::OUT_BIT]}};
         group2_pins_o.data_oe <= {16{cfg_reg[1][hshk_pkg::OUT_BIT]}};
      end
   end

   // Interrupt events: group data-ready, DMA terminal counts, counter-three edge
   assign isrc_ev = {cnt3_edge_i && route_reg[hshk_pkg::C3EN_BIT],
      dma_tc_i & route_reg[hshk_pkg::TCEN_LSB +: 2],
      data_ready_flag_reg & {cfg_reg[1][hshk_pkg::IRQEN_BIT], cfg_reg[0][hshk_pkg::IRQEN_BIT]}}; // RULE15 RULE22

   // Sticky interrupt sources; a new event wins over the clear
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         isrc_reg <= 5'h00;
      else
      begin
         for (int i = 0; i < 5; i++)
         begin
            if (isrc_ev[i])
               isrc_reg[i] <= 1'b1; // RULE15 RULE22
            else if (wr_i && addr_i == hshk_pkg::IRQCLR_OFS && wdata_i[i])
               isrc_reg[i] <= 1'b0; // RULE15
         end
      end
   end

   // Route group requests to selected host lines and channels
   always_comb
   begin
      irq_next = 11'h000;
      dma_next = 3'h0;
      for (int g = 0; g < 2; g++)
      begin
         logic [3:0] sel;
         logic [1:0] ch;
         logic gi;
         sel = route_reg[(g == 0 ? hshk_pkg::IRQSEL1_LSB : hshk_pkg::IRQSEL2_LSB) +: 4];
         ch = route_reg[(g == 0 ? hshk_pkg::DMASEL1_LSB : hshk_pkg::DMASEL2_LSB) +: 2];
         gi = isrc_reg[g] || isrc_reg[g+2] || (g == 0 && isrc_reg[4]);
         // Codes above ten select no line
         if (gi && sel < 4'hB)
            irq_next[sel] = 1'b1; // RULE16
         // Channel codes 1..3 map to channels five to seven, 0 is off
         if (data_ready_flag_reg[g] && cfg_reg[g][hshk_pkg::GROUP_DMA_ENABLE_BIT] && ch != 2'h0)
            dma_next[ch - 2'h1] = 1'b1; // RULE17 RULE18 RULE19 RULE21
      end
   end

   // Host request outputs: shared lines driven only while asserted
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         irq_line_o <= 11'h000;
         irq_line_oe_o <= 11'h000;
         dma_req_o <= 3'h0;
      end
      else
      begin
         irq_line_o <= irq_next;
         irq_line_oe_o <= irq_next; // RULE16
         dma_req_o <= dma_next;
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata_o <= 16'h0000;
      else if (rd_i)
      begin
         case (addr_i)
            hshk_pkg::CFG1_OFS: rdata_o <= cfg_reg[0];
            hshk_pkg::CFG2_OFS: rdata_o <= cfg_reg[1];
            hshk_pkg::ROUTE_OFS: rdata_o <= route_reg;
            hshk_pkg::PORT1_OFS: rdata_o <= cfg_reg[0][hshk_pkg::OUT_BIT] ? obuf_reg[0]
               : (cfg_reg[0][hshk_pkg::DBLBUF_BIT] ? ibuf_reg[0] : pin_in[0]);
            hshk_pkg::PORT2_OFS: rdata_o <= cfg_reg[1][hshk_pkg::OUT_BIT] ? obuf_reg[1]
               : (cfg_reg[1][hshk_pkg::DBLBUF_BIT] ? ibuf_reg[1] : pin_in[1]);
            hshk_pkg::STAT_OFS: rdata_o <= {5'h00, isrc_reg, req_lvl, ack_reg, data_ready_flag_reg};
            default: rdata_o <= 16'h0000;
         endcase
      end
      else
         rdata_o <= 16'h0000;
   end

   //////////////////////////////////////////////////////////////////////////
   // Length of the running group two acknowledge; a counter instead of a long repetition
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ack_run_reg <= 8'h00;
      else if (!ack_reg[1])
         ack_run_reg <= 8'h00;
      else if (ack_run_reg != 8'hFF)
         ack_run_reg <= ack_run_reg + 8'h01;
   end

   a_local_group_reset_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cfg_reg[0][hshk_pkg::LOCAL_GROUP_RESET_BIT] |=> st_reg[0] == ST_IDLE && !data_ready_flag_reg[0]) // RULE4
      else $error("local reset did not idle group");
   a_out_data_ready_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
      st_reg[1] == ST_IDLE && cfg_reg[1][0] && !cfg_reg[1][6] |=> data_ready_flag_reg[1]) // RULE6
      else $error("write group not ready");
   a_access_clears: assert property (@(posedge clk_i) disable iff (!nrst_i)
      st_reg[0] == ST_READY && grp[0].access && !cfg_reg[0][6] |=> !data_ready_flag_reg[0]) // RULE5 RULE6
      else $error("port access left data-ready set");
   a_trail_ack: assert property (@(posedge clk_i) disable iff (!nrst_i)
      mode_of(cfg_reg[1]) == hshk_pkg::MODE_TRAIL && !ack_reg[1] && ack_run_reg != 8'h00
      |-> ack_run_reg >= hshk_pkg::MIN_ACK_CYC) // RULE13
      else $error("trailing ack shorter than 100 ns");
   a_dma_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
      data_ready_flag_reg[0] && cfg_reg[0][12] && route_reg[9:8] == 2'h1 |=> dma_req_o[0]) // RULE21
      else $error("dma request missing");
   a_ack_pin: assert property (@(posedge clk_i) disable iff (!nrst_i)
      1'b1 |=> group1_pins_o.ack == ($past(ack_reg[0]) ^ $past(cfg_reg[0][1]))) // RULE7
      else $error("ack polarity wrong");
   a_irq_oe: assert property (@(posedge clk_i) disable iff (!nrst_i)
      irq_line_o == irq_line_oe_o) // RULE16
      else $error("irq line driven while inactive");
   a_irq_sticky: assert property (@(posedge clk_i) disable iff (!nrst_i)
      data_ready_flag_reg[0] && cfg_reg[0][11] |=> isrc_reg[0]) // RULE22
      else $error("interrupt source lost");

endmodule

// ### testbench/hshk_peer.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Peripheral on the far side of one handshake group
module hshk_peer
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Control from the bench
   input wire logic go_i,
   input wire logic auto_i,
   input wire logic wide_i,
   input wire logic inv_i,
   // Handshake pins
   input wire logic ack_i,
   output logic req_o
);
   logic ack_q;
   logic [4:0] cnt;
   ////////////////////////////////////////////////////////////////////////////////
   // Pulse starts some cycles after its trigger, like a slow peripheral
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ack_q <= 1'b0;
         cnt <= 5'h00;
      end
      else
      begin
         ack_q <= ack_i ^ inv_i;
         if (go_i || (auto_i && (ack_i ^ inv_i) && !ack_q))
            cnt <= wide_i ? 5'h18 : 5'h08;
         else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
      end
   end
   // Request always falls before rising again, so each pulse has both edges
   assign req_o = ((cnt != 5'h00) && (cnt <= (wide_i ? 5'h14 : 5'h05))) ^ inv_i;
endmodule

// ### testbench/tb_hshk_io.sv
`timescale 1ns/1ns
module tb_hshk_io;
   localparam logic [15:0] DAT1 = 16'hA5C3;
   localparam logic [15:0] DAT2 = 16'h5A3C;
   logic clk_i, nrst_i, wr_i, rd_i, cnt3_edge_i;
   logic [3:0] addr_i;
   logic [15:0] wdata_i, rdata_o, st;
   logic [1:0] go, auto, wide, inv, dma_tc_i;
   wire [1:0] req;
   logic [10:0] irq_line_o, irq_line_oe_o;
   logic [2:0] dma_req_o;
   hshk_pkg::grp_pins_t g1_pins, g2_pins;
   int err_count, checks_done, w;
   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   hshk_io DUT
   (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .request_in_i(req),
      .group1_data_i(DAT1),
      .group2_data_i(DAT2),
      .group1_pins_o(g1_pins),
      .group2_pins_o(g2_pins),
      .dma_tc_i(dma_tc_i),
      .cnt3_edge_i(cnt3_edge_i),
      .irq_line_o(irq_line_o),
      .irq_line_oe_o(irq_line_oe_o),
      .dma_req_o(dma_req_o)
   );
   hshk_peer peer_g1 (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go[0]), .auto_i(auto[0]), .wide_i(wide[0]),
      .inv_i(inv[0]), .ack_i(g1_pins.ack), .req_o(req[0]));
   hshk_peer peer_g2 (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(go[1]), .auto_i(auto[1]), .wide_i(wide[1]),
      .inv_i(inv[1]), .ack_i(g2_pins.ack), .req_o(req[1]));
   ////////////////////////////////////////////////////////////////////////////////
   // Checking and bus tasks; each access leaves a spare cycle behind it
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      st = rdata_o;
      @(posedge clk_i);
   endtask
   task automatic pulse(input int g);
      go[g] <= 1'b1;
      @(posedge clk_i);
      go[g] <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic do_reset;
      auto <= 2'b00;
      wide <= 2'b00;
      inv <= 2'b00;
      nrst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
   endtask
   // Polls a status bit, bounded
   task automatic wait_st(input int b, input logic v);
      int n;
      n = 0;
      rd(hshk_pkg::STAT_OFS);
      while (st[b] !== v && n < 40)
      begin
         rd(hshk_pkg::STAT_OFS);
         n++;
      end
      chk(16'(st[b]), 16'(v));
   endtask
   // Counts cycles until (stay=0) or while (stay=1) the ack pin shows v
   task automatic span(input int g, input logic v, input logic stay, input int lo, input int hi);
      int n;
      n = 0;
      @(negedge clk_i);
      while (((g ? g2_pins.ack : g1_pins.ack) === v) == stay && n < hi + 2)
      begin
         @(negedge clk_i);
         n++;
      end
      chk(16'(n >= lo && n <= hi), 16'h0001);
      @(posedge clk_i);
   endtask
   function automatic logic [15:0] cfgw(input logic o, input hshk_pkg::hs_mode_t m, input logic lp,
      input logic [2:0] d);
      logic [15:0] v;
      v = 16'h0000;
      v[hshk_pkg::OUT_BIT] = o;
      v[hshk_pkg::PULSE_BIT] = m != hshk_pkg::MODE_LEVEL;
      v[hshk_pkg::EDGE_BIT] = m == hshk_pkg::MODE_TRAIL;
      v[hshk_pkg::LONG_ACK_PULSE_OPTION_BIT] = lp;
      v[hshk_pkg::DLY_LSB +: 3] = d;
      return v;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   // Hang guard, well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (30000) @(posedge clk_i);
      $display("watchdog expired");
      err_count++;
      conclude;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial
   begin
      nrst_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 16'h0000;
      wr_i = 1'b0;
      rd_i = 1'b0;
      go = 2'b00;
      auto = 2'b00;
      wide = 2'b00;
      inv = 2'b00;
      dma_tc_i = 2'b00;
      cnt3_edge_i = 1'b0;
      err_count = 0;
      checks_done = 0;
      w = hshk_pkg::DLY_STEP_CYC;
      do_reset;
      rd(hshk_pkg::STAT_OFS);
      chk(st, 16'h0000);
      chk({5'h00, irq_line_oe_o}, 16'h0000);
      chk({12'h000, dma_req_o, g1_pins.ack | g2_pins.ack}, 16'h0000);
      rd(4'hF);
      chk(st, 16'h0000);
      $display("test reset done");
      wr(hshk_pkg::CFG1_OFS, cfgw(1'b0, hshk_pkg::MODE_LEVEL, 1'b0, 3'h1));
      wait_st(0, 1'b0);
      auto <= 2'b01;
      pulse(0);
      wait_st(0, 1'b1);
      rd(hshk_pkg::PORT1_OFS);
      span(0, 1'b1, 1'b0, w - 2, w + 3);
      chk(st, DAT1);
      span(0, 1'b0, 1'b0, 2, 14);
      wait_st(0, 1'b1);
      $display("test level done");
      for (int d = 0; d <= 2; d += 2)
      begin
         do_reset;
         w = (d == 0) ? int'(hshk_pkg::MIN_ACK_CYC) : d * hshk_pkg::DLY_STEP_CYC;
         wr(hshk_pkg::CFG2_OFS, cfgw(1'b0, hshk_pkg::MODE_TRAIL, 1'b0, 3'(d))
            | (16'(d / 2) << hshk_pkg::DBLBUF_BIT));
         pulse(1);
         wait_st(1, 1'b1);
         rd(hshk_pkg::PORT2_OFS);
         span(1, 1'b1, 1'b0, 0, 2);
         span(1, 1'b1, 1'b1, w - 2, w + 1);
         chk(st, DAT2);
         wide <= 2'b10;
         pulse(1);
         repeat (10) @(posedge clk_i);
         rd(hshk_pkg::STAT_OFS);
         chk(16'(st[1]), 16'h0000);
         wait_st(1, 1'b1);
      end
      $display("test trailing done");
      w = hshk_pkg::DLY_STEP_CYC;
      for (int lp = 0; lp < 2; lp++)
      begin
         do_reset;
         wr(hshk_pkg::CFG2_OFS, cfgw(1'b1, hshk_pkg::MODE_LEAD, 1'(lp), 3'h1)
            | (16'(lp) << hshk_pkg::DBLBUF_BIT));
         wait_st(1, 1'b1);
         wr(hshk_pkg::PORT2_OFS, DAT1 ^ 16'(lp));
         span(1, 1'b1, 1'b0, lp ? 0 : w - 2, lp ? 2 : w + 3);
         chk(g2_pins.data, lp ? 16'h0000 : DAT1);
         chk(g2_pins.data_oe, 16'hFFFF);
         wait_st(1, 1'b0);
         pulse(1);
         wait_st(1, 1'b1);
         chk(g2_pins.data, DAT1 ^ 16'(lp));
      end
      $display("test leading done");
      do_reset;
      // Group one inverted, irq line 2, DMA channel five, terminal count one and counter-three events on
      wr(hshk_pkg::ROUTE_OFS, 16'h51F2);
      inv <= 2'b01;
      wr(hshk_pkg::CFG1_OFS, cfgw(1'b0, hshk_pkg::MODE_LEVEL, 1'b0, 3'h1) | 16'h1862);
      repeat (6) @(posedge clk_i);
      wr(hshk_pkg::CFG1_OFS, cfgw(1'b0, hshk_pkg::MODE_LEVEL, 1'b0, 3'h1) | 16'h1822);
      rd(hshk_pkg::STAT_OFS);
      chk(16'({dma_req_o, st[0]}), 16'h0000);
      chk(16'(g1_pins.ack), 16'h0001);
      pulse(0);
      wait_st(0, 1'b1);
      // Interrupt line trails data-ready by two edges; look once it has settled
      @(negedge clk_i);
      chk(16'(dma_req_o), 16'h0001);
      chk(16'({irq_line_oe_o[2], irq_line_o[2]}), 16'h0003);
      @(posedge clk_i);
      rd(hshk_pkg::PORT1_OFS);
      span(0, 1'b0, 1'b0, w - 2, w + 3);
      chk(16'(dma_req_o), 16'h0000);
      dma_tc_i <= 2'b01;
      cnt3_edge_i <= 1'b1;
      @(posedge clk_i);
      dma_tc_i <= 2'b00;
      cnt3_edge_i <= 1'b0;
      wait_st(8, 1'b1);
      wait_st(10, 1'b1);
      wr(hshk_pkg::IRQCLR_OFS, 16'h0014);
      wait_st(8, 1'b0);
      wait_st(10, 1'b0);
      $display("test polarity_events done");
      conclude;
   end
endmodule
